//--- src/dma_mode_pkg.sv
// Purpose: shared constants for the four-channel transfer mode control block
// Assumes: APB slave with 32-bit words, one register per aligned word
// Notes: encodings of request source and transfer mode are local choices
// Overview of operation
// RULE_01: Each channel has a transfer-enable bit at bit 31 of its mode register, reset to 0.
// RULE_02: With auto-request selected, setting the enable bit starts the channel at once.
// RULE_03: With module or external requests, only a request after the bit is set starts it.
// RULE_04: Writing 0 to the enable bit while data moves stops the channel.
// RULE_05: In block mode a written 0 takes effect only when the current block has finished.
// RULE_06: An external stop or suspend event clears the enable bit and stops the channel.
// RULE_07: Software keeps mode and method settings unchanged while the enable bit reads 1.
// RULE_08: Total size done, repeat or extended repeat overflow and size error clear the bit.
// RULE_09: An address error or a non-maskable interrupt request clears the enable bit.
// RULE_10: The enable bit is held at 0 in reset and in hardware standby.
// RULE_11: Error, extended-size and end flags clear only by writing 0 after reading 1.
// RULE_12: The system error flag lives only in channel 0; elsewhere it reads 0.
// RULE_13: While the system error flag is 1, writes to every enable bit are ignored.
// RULE_14: The active bit reads 1 while running and 0 while waiting or disabled.
// RULE_15: Four independent channels share only the error flag held in channel 0.
package dma_mode_pkg;
	localparam int NUM_CH = 4;
	localparam logic [7:0] OFS_CH0_MODE = 8'h00;
	localparam logic [7:0] OFS_CH1_MODE = 8'h04;
	localparam logic [7:0] OFS_CH2_MODE = 8'h08;
	localparam logic [7:0] OFS_CH3_MODE = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK = 32'h6c00_fbe7;
	localparam int BIT_XFER_ENABLE = 31;
	localparam int BIT_ACTIVE = 23;
	localparam int BIT_SYS_ERR = 19;
	localparam int BIT_EXT_SIZE_IRQ = 17;
	localparam int BIT_XFER_END_IRQ = 16;
	localparam int MODE_HI = 13;
	localparam int MODE_LO = 12;
	localparam int SRC_HI = 7;
	localparam int SRC_LO = 6;
	localparam logic [1:0] SRC_AUTO = 2'h0;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam int IRQ_PER_CH = 3;
	localparam int IRQ_W = NUM_CH * IRQ_PER_CH;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 12'h000;
endpackage

//--- src/dma_irq_status.sv
// Purpose: sticky event status with clear-on-read and a mask
// Assumes: clear bits are the value that the read returned
// Notes: a set in the clearing cycle survives
`timescale 1ns/100ps
`default_nettype none
module dma_irq_status
	import dma_mode_pkg::*;
#(
	parameter int W = IRQ_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] set_bits,
	input wire logic rd_clear,
	input wire logic [W-1:0] clr_bits,
	input wire logic mask_wr,
	input wire logic [W-1:0] mask_wdata,
	output logic [W-1:0] status_q,
	output logic [W-1:0] mask_q,
	output logic irq
);
	// only bits already returned are cleared, so a late event is not lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= '0;
		end else begin
			status_q <= set_bits | (status_q & ~(rd_clear ? clr_bits : '0));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= '0;
		end else if (mask_wr) begin
			mask_q <= mask_wdata;
		end
	end

	assign irq = |(status_q & mask_q);
endmodule
`default_nettype wire

//--- src/dma_mode_channel.sv
// Purpose: one channel's mode register and transfer-enable control
// Assumes: event inputs are one-cycle pulses from the transfer datapath
// Notes: the system error flag exists only when HAS_ERR is set
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module dma_mode_channel
	import dma_mode_pkg::*;
#(
	parameter bit HAS_ERR = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic rd_setup,
	input wire logic [31:0] wdata,
	input wire logic err_lock,
	input wire logic hw_standby,
	input wire logic sys_err_evt,
	input wire logic xfer_req,
	input wire logic unit_done,
	input wire logic block_done,
	input wire logic total_done,
	input wire logic repeat_ovf,
	input wire logic ext_repeat_ovf,
	input wire logic size_err,
	input wire logic ext_stop,
	output logic [31:0] rdata,
	output logic xfer_run,
	output logic active,
	output logic err_flag
);
	logic en_q, en_d, act_q, act_d, stop_pend_q;
	logic extended_size_irq_flag_q, xfer_end_irq_flag_q, system_error_flag_q;
	logic extended_size_irq_flag_arm_q, xfer_end_irq_flag_arm_q, system_error_flag_arm_q;
	logic [31:0] cfg_q;
	logic src_auto, wr_auto, block_mode, en_wr, hw_stop, late_stop;

	function automatic logic flag_next(input logic flag, input logic set, input logic clr);
		flag_next = set | (flag & ~clr);
	endfunction

	assign src_auto = (cfg_q[SRC_HI:SRC_LO] == SRC_AUTO);
	// the enabling write carries its own source field; the stored copy is still the old one
	assign wr_auto = (wdata[SRC_HI:SRC_LO] == SRC_AUTO);
	assign block_mode = (cfg_q[MODE_HI:MODE_LO] == MODE_BLOCK);
	assign en_wr = wr_en && !err_lock; // RULE_13
	assign hw_stop = total_done | repeat_ovf | ext_repeat_ovf | size_err // RULE_08
		| ext_stop // RULE_06
		| sys_err_evt // RULE_09
		| hw_standby; // RULE_10
	// a 0 written mid-block is parked until the block ends
	assign late_stop = en_wr && !wdata[BIT_XFER_ENABLE] && block_mode && act_q && en_q;

	always_comb begin
		en_d = en_q;
		if (hw_stop) begin
			en_d = 1'b0;
		end else if (stop_pend_q && block_done) begin
			en_d = 1'b0; // RULE_05
		end else if (en_wr) begin
			if (wdata[BIT_XFER_ENABLE]) begin
				en_d = 1'b1; // RULE_01
			end else if (!late_stop) begin
				en_d = 1'b0; // RULE_04
			end
		end
	end

	always_comb begin
		act_d = act_q;
		if (!en_d) begin
			act_d = 1'b0;
		end else if (wr_auto && en_wr && wdata[BIT_XFER_ENABLE]) begin
			act_d = 1'b1; // RULE_02
		end else if (xfer_req && en_q && !src_auto) begin
			act_d = 1'b1; // RULE_03
		end else if (unit_done && !src_auto) begin
			act_d = 1'b0; // RULE_14
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= 1'b0; // RULE_10
			act_q <= 1'b0;
			stop_pend_q <= 1'b0;
		end else begin
			en_q <= en_d;
			act_q <= act_d;
			stop_pend_q <= en_d && (late_stop || (stop_pend_q && !en_wr));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= MODE_RESET;
		end else if (wr_en) begin
			cfg_q <= wdata & CFG_MASK;
		end
	end

	// read of a set flag arms the clear; any later write disarms it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			extended_size_irq_flag_arm_q <= 1'b0;
			xfer_end_irq_flag_arm_q <= 1'b0;
			system_error_flag_arm_q <= 1'b0;
		end else if (wr_en) begin
			extended_size_irq_flag_arm_q <= 1'b0;
			xfer_end_irq_flag_arm_q <= 1'b0;
			system_error_flag_arm_q <= 1'b0;
		end else if (rd_setup) begin
			extended_size_irq_flag_arm_q <= extended_size_irq_flag_arm_q | extended_size_irq_flag_q;
			xfer_end_irq_flag_arm_q <= xfer_end_irq_flag_arm_q | xfer_end_irq_flag_q;
			system_error_flag_arm_q <= system_error_flag_arm_q | system_error_flag_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			extended_size_irq_flag_q <= 1'b0;
			xfer_end_irq_flag_q <= 1'b0;
			system_error_flag_q <= 1'b0;
		end else begin
			extended_size_irq_flag_q <= flag_next(extended_size_irq_flag_q, ext_repeat_ovf,
				wr_en && !wdata[BIT_EXT_SIZE_IRQ] && extended_size_irq_flag_arm_q); // RULE_11
			xfer_end_irq_flag_q <= flag_next(xfer_end_irq_flag_q, total_done,
				wr_en && !wdata[BIT_XFER_END_IRQ] && xfer_end_irq_flag_arm_q); // RULE_11
			system_error_flag_q <= HAS_ERR && flag_next(system_error_flag_q, sys_err_evt,
				wr_en && !wdata[BIT_SYS_ERR] && system_error_flag_arm_q); // RULE_12
		end
	end

	always_comb begin
		rdata = cfg_q;
		rdata[BIT_XFER_ENABLE] = en_q;
		rdata[BIT_ACTIVE] = act_q && en_q; // RULE_14
		rdata[BIT_SYS_ERR] = system_error_flag_q;
		rdata[BIT_EXT_SIZE_IRQ] = extended_size_irq_flag_q;
		rdata[BIT_XFER_END_IRQ] = xfer_end_irq_flag_q;
	end

	assign xfer_run = act_q && en_q;
	assign active = act_q && en_q;
	assign err_flag = system_error_flag_q;
endmodule
`default_nettype wire

//--- src/dma_channel_mode_control.sv
// Purpose: APB front end holding four channel mode registers and an event interrupt
// Assumes: datapath event inputs are single-cycle pulses on pclk
// Notes: zero wait states; unmapped addresses answer with pslverr
`timescale 1ns/100ps
`default_nettype none
module dma_channel_mode_control
	import dma_mode_pkg::*;
#(
	parameter int CH = NUM_CH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hw_standby,
	input wire logic addr_error,
	input wire logic nmi_req,
	input wire logic [CH-1:0] xfer_req,
	input wire logic [CH-1:0] unit_done,
	input wire logic [CH-1:0] block_done,
	input wire logic [CH-1:0] total_done,
	input wire logic [CH-1:0] repeat_ovf,
	input wire logic [CH-1:0] ext_repeat_ovf,
	input wire logic [CH-1:0] size_err,
	input wire logic [CH-1:0] ext_stop,
	output logic [CH-1:0] xfer_run,
	output logic [CH-1:0] chan_active,
	output logic irq
);
	logic setup, access_wr, access_rd;
	logic [31:0] prdata_q, rd_mux;
	logic [31:0] ch_rdata [CH];
	logic [CH-1:0] ch_err;
	logic [IRQ_W-1:0] irq_set, irq_status, irq_mask;
	logic sys_err_evt, err_lock;

	// index 0..3 for a mode register, 4 status, 5 mask, 7 unmapped
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		if (a == OFS_CH0_MODE) reg_index = 3'h0;
		else if (a == OFS_CH1_MODE) reg_index = 3'h1;
		else if (a == OFS_CH2_MODE) reg_index = 3'h2;
		else if (a == OFS_CH3_MODE) reg_index = 3'h3;
		else if (a == OFS_IRQ_STATUS) reg_index = 3'h4;
		else if (a == OFS_IRQ_MASK) reg_index = 3'h5;
		else reg_index = 3'h7;
	endfunction

	assign setup = psel && !penable;
	assign access_wr = psel && penable && pwrite;
	assign access_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && (reg_index(paddr) == 3'h7);
	assign prdata = prdata_q;
	assign sys_err_evt = addr_error | nmi_req;
	assign err_lock = ch_err[0]; // RULE_15

	genvar i;
	generate
		for (i = 0; i < CH; i++) begin : g_ch
			dma_mode_channel #(
				.HAS_ERR(i == 0)
			) u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(access_wr && (reg_index(paddr) == 3'(i))),
				.rd_setup(setup && !pwrite && (reg_index(paddr) == 3'(i))),
				.wdata(pwdata),
				.err_lock(err_lock),
				.hw_standby(hw_standby),
				.sys_err_evt(sys_err_evt),
				.xfer_req(xfer_req[i]),
				.unit_done(unit_done[i]),
				.block_done(block_done[i]),
				.total_done(total_done[i]),
				.repeat_ovf(repeat_ovf[i]),
				.ext_repeat_ovf(ext_repeat_ovf[i]),
				.size_err(size_err[i]),
				.ext_stop(ext_stop[i]),
				.rdata(ch_rdata[i]),
				.xfer_run(xfer_run[i]),
				.active(chan_active[i]),
				.err_flag(ch_err[i])
			);
			assign irq_set[i*IRQ_PER_CH] = total_done[i];
			assign irq_set[i*IRQ_PER_CH+1] = ext_repeat_ovf[i];
			assign irq_set[i*IRQ_PER_CH+2] = size_err[i];
		end
	endgenerate

	dma_irq_status #(
		.W(IRQ_W)
	) u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.set_bits(irq_set),
		.rd_clear(access_rd && (reg_index(paddr) == 3'h4)),
		.clr_bits(prdata_q[IRQ_W-1:0]),
		.mask_wr(access_wr && (reg_index(paddr) == 3'h5)),
		.mask_wdata(pwdata[IRQ_W-1:0]),
		.status_q(irq_status),
		.mask_q(irq_mask),
		.irq(irq)
	);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_index(paddr))
			3'h0: rd_mux = ch_rdata[0];
			3'h1: rd_mux = ch_rdata[1];
			3'h2: rd_mux = ch_rdata[2];
			3'h3: rd_mux = ch_rdata[3];
			3'h4: rd_mux = {20'h00000, irq_status};
			3'h5: rd_mux = {20'h00000, irq_mask};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is captured in setup so that read side effects match what is returned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end
endmodule
`default_nettype wire

//--- verif/dma_xfer_peer.sv
// Purpose: far-side model pacing requests and unit completions
// Assumes: one unit runs LAT+1 cycles
// Notes: go is a one-cycle command from the bench
`timescale 1ns/100ps
`default_nettype none
module dma_xfer_peer #(
	parameter int LAT = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] run,
	input wire logic [3:0] go,
	output logic [3:0] xfer_req,
	output logic [3:0] unit_done
);
	logic [3:0] cnt_q [4];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_req <= '0;
			unit_done <= '0;
			cnt_q <= '{default: '0};
		end else begin
			xfer_req <= go;
			for (int c = 0; c < 4; c++) begin
				unit_done[c] <= run[c] && cnt_q[c] == 4'(LAT);
				cnt_q[c] <= (run[c] && cnt_q[c] != 4'(LAT)) ? cnt_q[c] + 4'h1 : 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/dma_mode_sva.sv
// Purpose: port-level checks of the channel enable control
// Assumes: channel 0 writes carry the whole mode word
// Notes: err_seen_q is conservative, it never falls before reset
`timescale 1ns/100ps
`default_nettype none
module dma_mode_sva
	import dma_mode_pkg::*;
#(
	parameter int CH = NUM_CH
) (
	input wire logic pclk, presetn, psel, penable, pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic hw_standby, addr_error, nmi_req,
	input wire logic [CH-1:0] xfer_req, unit_done, block_done, total_done,
	input wire logic [CH-1:0] repeat_ovf, ext_repeat_ovf, size_err, ext_stop,
	input wire logic [CH-1:0] xfer_run, chan_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic err_seen_q;
	logic wr0;
	logic [CH-1:0] stop_evt;
	assign wr0 = psel && penable && pwrite && paddr == OFS_CH0_MODE;
	assign stop_evt = total_done | repeat_ovf | ext_repeat_ovf | size_err | ext_stop;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			err_seen_q <= 1'b0;
		else if (addr_error || nmi_req)
			err_seen_q <= 1'b1;
	end
	standby_off_a: assert property (hw_standby |=> xfer_run == '0)
		else $error("run during standby");
	err_stop_a: assert property (addr_error || nmi_req |=> xfer_run == '0)
		else $error("run after error event");
	evt_stop_a: assert property (|stop_evt |=> (xfer_run & $past(stop_evt)) == '0)
		else $error("run after stop event");
	active_eq_a: assert property (chan_active == xfer_run)
		else $error("active differs from run");
	auto_start_a: assert property (wr0 && pwdata[31] && pwdata[7:6] == SRC_AUTO
		&& !err_seen_q && !hw_standby && !addr_error && !nmi_req && !stop_evt[0]
		|=> ##[0:1] xfer_run[0])
		else $error("auto start missing");
	sw_stop_a: assert property (wr0 && !pwdata[31] && pwdata[13:12] != MODE_BLOCK
		&& !err_seen_q |=> !xfer_run[0])
		else $error("write 0 did not stop");
	block_hold_a: assert property (wr0 && !pwdata[31] && pwdata[13:12] == MODE_BLOCK
		&& xfer_run[0] && !block_done[0] && !unit_done[0] && !stop_evt[0]
		&& !hw_standby && !addr_error && !nmi_req |=> xfer_run[0])
		else $error("block cut short");
	rise_cause_a: assert property ($rose(xfer_run[0]) |-> $past(wr0) || $past(wr0, 2)
		|| $past(xfer_req[0]) || $past(unit_done[0]) || $past(unit_done[0], 2))
		else $error("start without cause");
endmodule
bind dma_channel_mode_control dma_mode_sva #(.CH(CH)) u_dma_mode_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .hw_standby(hw_standby), .addr_error(addr_error),
	.nmi_req(nmi_req), .xfer_req(xfer_req), .unit_done(unit_done),
	.block_done(block_done), .total_done(total_done), .repeat_ovf(repeat_ovf),
	.ext_repeat_ovf(ext_repeat_ovf), .size_err(size_err), .ext_stop(ext_stop),
	.xfer_run(xfer_run), .chan_active(chan_active)
);
`default_nettype wire

//--- verif/tb_dma_channel_mode_control.sv
// Purpose: self-checking bench for the channel mode control block
// Assumes: zero-wait APB slave, peer model paces units
// Notes: fixed seed keeps runs repeatable
`timescale 1ns/100ps
`default_nettype none
module tb_dma_channel_mode_control
	import dma_mode_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_q;
	logic hw_standby, addr_error, nmi_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q, w;
	logic [3:0] xfer_req, unit_done, block_done, total_done, repeat_ovf, go;
	logic [3:0] ext_repeat_ovf, size_err, ext_stop, xfer_run, chan_active;
	int mismatches, total_checks;
	dma_channel_mode_control u_dma_channel_mode_control (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hw_standby(hw_standby), .addr_error(addr_error), .nmi_req(nmi_req),
		.xfer_req(xfer_req), .unit_done(unit_done), .block_done(block_done),
		.total_done(total_done), .repeat_ovf(repeat_ovf), .ext_repeat_ovf(ext_repeat_ovf),
		.size_err(size_err), .ext_stop(ext_stop), .xfer_run(xfer_run),
		.chan_active(chan_active), .irq(irq));
	dma_xfer_peer u_dma_xfer_peer (.pclk(pclk), .presetn(presetn), .run(xfer_run),
		.go(go), .xfer_req(xfer_req), .unit_done(unit_done));
	function automatic logic [11:0] irq_exp(input int k, input int c);
		return (k == 0) ? 12'h1 << 3*c : (k == 2) ? 12'h2 << 3*c : (k == 3) ? 12'h4 << 3*c : 12'h0;
	endfunction
	task ck(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task xf(input logic wt, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wt, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_q = prdata;
		err_q = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rn(input int c, input logic e);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		ck("run", e, xfer_run[c]);
		ck("active", e, chan_active[c]);
	endtask
	task rq(input logic [3:0] m);
		@(posedge pclk);
		go <= m;
		@(posedge pclk);
		go <= '0;
	endtask
	task ev(input int k, input logic [3:0] m);
		@(posedge pclk);
		case (k)
			0: total_done <= m;
			1: repeat_ovf <= m;
			2: ext_repeat_ovf <= m;
			3: size_err <= m;
			4: ext_stop <= m;
			5: block_done <= m;
			6: nmi_req <= m[0];
			default: addr_error <= m[0];
		endcase
		@(posedge pclk);
		{total_done, repeat_ovf, ext_repeat_ovf, size_err, ext_stop, block_done} <= '0;
		{nmi_req, addr_error} <= 2'b00;
		@(negedge pclk);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		final_report;
	end
	initial begin
		{presetn, psel, penable, pwrite, hw_standby, addr_error, nmi_req} = '0;
		{paddr, pwdata, go, block_done, total_done, repeat_ovf} = '0;
		{ext_repeat_ovf, size_err, ext_stop} = '0;
		mismatches = 0;
		total_checks = 0;
		void'($urandom(32'h0c93));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 24; a += 4) begin
			xf(0, 8'(a), 0);
			ck("reset", MODE_RESET, rd_q);
			ck("slverr", 0, err_q);
		end
		xf(0, 8'h20, 0);
		ck("unmapped", 1, err_q);
		for (int c = 0; c < 4; c++) begin
			w = $urandom() & 32'h7fff_ffff;
			xf(1, 8'(4*c), w);
			xf(0, 8'(4*c), 0);
			ck("config", w & CFG_MASK, rd_q);
		end
		xf(1, OFS_CH0_MODE, 32'h8000_0000);
		rn(0, 1);
		xf(1, OFS_CH0_MODE, 32'h0);
		rn(0, 0);
		xf(1, OFS_IRQ_MASK, 32'hfff);
		for (int k = 0; k < 5; k++) begin
			xf(1, OFS_CH3_MODE, 32'h8000_0040);
			rn(3, 0);
			rq(4'h8);
			rn(3, 1);
			ev(k, 4'h8);
			ck("stop", 0, xfer_run[3]);
			ck("irq", irq_exp(k, 3) != 0, irq);
			xf(0, OFS_IRQ_STATUS, 0);
			ck("status", irq_exp(k, 3), rd_q);
			xf(0, OFS_CH3_MODE, 0);
			ck("enable", 0, rd_q[31]);
		end
		xf(1, OFS_IRQ_MASK, 0);
		ev(0, 4'h8);
		ck("masked", 0, irq);
		xf(1, OFS_CH0_MODE, 32'h8000_2040);
		rq(4'h1);
		xf(1, OFS_CH0_MODE, 32'h0000_2040);
		xf(0, OFS_CH0_MODE, 0);
		ck("block hold", 1, rd_q[31]);
		ev(5, 4'h1);
		xf(0, OFS_CH0_MODE, 0);
		ck("block end", 0, rd_q[31]);
		xf(1, OFS_CH1_MODE, 32'h8000_0000);
		hw_standby <= 1'b1;
		rn(1, 0);
		xf(0, OFS_CH1_MODE, 0);
		ck("standby", 0, rd_q[31]);
		hw_standby <= 1'b0;
		for (int k = 6; k < 8; k++) begin
			xf(1, OFS_CH1_MODE, 32'h8000_0000);
			ev(k, 4'h1);
			ck("err stop", 0, xfer_run);
			xf(1, OFS_CH1_MODE, 32'h8000_0000);
			rn(1, 0);
			xf(0, OFS_CH0_MODE, 0);
			ck("err flag", 1, rd_q[19]);
			xf(1, OFS_CH0_MODE, 32'h0008_0000);
			xf(0, OFS_CH0_MODE, 0);
			ck("flag w1", 1, rd_q[19]);
			xf(1, OFS_CH0_MODE, 0);
			xf(0, OFS_CH0_MODE, 0);
			ck("flag clr", 0, rd_q[19]);
			xf(0, OFS_CH1_MODE, 0);
			ck("ch1 err bit", 0, rd_q[19]);
		end
		final_report;
	end
endmodule
`default_nettype wire
